// ===== rtl/pep_cfg.svh
/*
  Offsets, field positions, reset values and sizes of the port pin block.
  Assumes a Wishbone slave decoding byte address bits [7:2] as a word
  index; every register sits in the low byte lanes of its word.
*/
`ifndef PEP_CFG_SVH
`define PEP_CFG_SVH

// word indices (byte address = index * 4)
`define PEP_W_IN        6'h00
`define PEP_W_CTRL      6'h01
`define PEP_W_FLAG      6'h02

// register groups: word index bits [5:3], entry in bits [2:0]
`define PEP_G_DATA      3'h1
`define PEP_G_DIR       3'h2
`define PEP_G_OD        3'h3
`define PEP_G_PAIR      3'h4
`define PEP_OD_CNT      3'h3
`define PEP_PAIR_CNT    3'h3

// control field positions
`define PEP_C_SCK_ALT   0
`define PEP_C_SO_ALT    1
`define PEP_C_POL_A     2
`define PEP_C_POL_B     3
`define PEP_C_TO_A      4
`define PEP_C_TO_B      5
`define PEP_C_PCL       6
`define PEP_CTRL_W      7

// reset values
`define PEP_CTRL_RST    7'h00
`define PEP_DAT_RST     4'h0
`define PEP_DIR_RST     4'h0
`define PEP_OD_RST      4'hf
`define PEP_FLAG_RST    2'h0

// bit-wise programmable ports among ports 2..9 (entry index)
`define PEP_BW_A        1
`define PEP_BW_B        4

// sizes
`define PEP_IO_PORTS    8
`define PEP_EDGES       7
`define PEP_SYNC_W      54

`endif

// ===== rtl/pep_pkg.sv
/*
  Types shared by the port pin block and its edge detector.
  Assumes nothing beyond a SystemVerilog tool.
*/
package pep_pkg;

  typedef logic [3:0] pep_nib_t;

  typedef enum logic [1:0] {
    PEP_EDGE_RISE,
    PEP_EDGE_FALL,
    PEP_EDGE_BOTH
  } pep_edge_e;

endpackage

// ===== rtl/pep_edge_det.sv
/*
  One edge detector: compares a synchronised level with its last sample
  and flags the edges selected by the mode.
  Assumes level_in is already on mclk_in and arm_in stays low until the
  synchroniser ahead of it holds real pin values.
*/
module pep_edge_det (
  // clock and reset
  input  wire logic                mclk_in,
  input  wire logic                rst_b_in,
  // level and selection
  input  wire logic                arm_in,
  input  wire logic                level_in,
  input  wire pep_pkg::pep_edge_e  mode_in,
  // result
  output logic                     hit_out
);
  import pep_pkg::*;

  logic prev_r;
  wire  rise_w = level_in & ~prev_r;
  wire  fall_w = ~level_in & prev_r;
  logic hit_w;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level_in;
    end
  end

  always_comb begin
    unique case (mode_in)
      PEP_EDGE_RISE: begin
        hit_w = rise_w;
      end
      PEP_EDGE_FALL: begin
        hit_w = fall_w;
      end
      PEP_EDGE_BOTH: begin
        hit_w = rise_w | fall_w;
      end
      default: begin
        hit_w = 1'b0;
      end
    endcase
  end

  // unarmed, prev_r still tracks so no stale edge fires at arming
  assign hit_out = arm_in & hit_w;

endmodule

// ===== rtl/pep_port_top.sv
/*
  Pin logic of the digital ports: input ports with edge inputs, serial drives on port a,
  bidirectional ports 2..9 with pairing and alternate functions, three
  open-drain ports, all behind a classic Wishbone slave.
  Assumes timers, serial unit and clock generator feed their pin signals
  on mclk_in; pad wires are resolved outside from the enables.
*/
// Design decisions made here: the address map and register access over Wishbone.
`include "pep_cfg.svh"

module pep_port_top (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  // wishbone slave
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [7:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  // input pins and the serial drives of port a
  input  wire pep_pkg::pep_nib_t input_port_a_in,
  input  wire pep_pkg::pep_nib_t input_port_b_in,
  input  wire logic              event_in_a_in,
  input  wire logic              event_in_b_in,
  output pep_pkg::pep_nib_t      input_port_a_drv_out,
  output pep_pkg::pep_nib_t      input_port_a_oe_out,
  // ports 2..9, four bits each, port 2 in bits [3:0]
  input  wire logic [31:0]       port_pins_in,
  output logic      [31:0]       port_pins_out,
  output logic      [31:0]       port_pins_oe_out,
  // open-drain ports a, b, c, port a in bits [3:0]
  input  wire logic [11:0]       open_drain_pins_in,
  output logic      [11:0]       open_drain_pins_out,
  output logic      [11:0]       open_drain_pins_oe_out,
  // on-chip function sources
  input  wire logic              timer_out_a_in,
  input  wire logic              timer_out_b_in,
  input  wire logic              prog_clock_src_in,
  input  wire logic              sck_master_in,
  input  wire logic              sck_drive_in,
  input  wire logic              serial_tx_in,
  // on-chip function sinks
  output logic                   sck_sync_out,
  output logic                   serial_rx_out,
  output logic                   event_a_out,
  output logic                   event_b_out,
  output logic      [4:0]        irq_req_out,
  output logic      [1:0]        test_flag_out
);
  import pep_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  logic [`PEP_SYNC_W-1:0] sync1_r;
  logic [`PEP_SYNC_W-1:0] sync2_r;
  logic [2:0]             settle_r;

  wire [`PEP_SYNC_W-1:0] raw_w = {open_drain_pins_in, port_pins_in,
                                  event_in_b_in, event_in_a_in,
                                  input_port_b_in, input_port_a_in};

  // sync1_r feeds sync2_r only
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_r  <= '0;
      sync2_r  <= '0;
      settle_r <= 3'h0;
    end else begin
      sync1_r  <= raw_w;
      sync2_r  <= sync1_r;
      settle_r <= {settle_r[1:0], 1'b1};
    end
  end

  wire pep_nib_t    pa_s  = sync2_r[3:0];
  wire pep_nib_t    pb_s  = sync2_r[7:4];
  wire              eva_s = sync2_r[8];
  wire              evb_s = sync2_r[9];
  wire [31:0]       io_s  = sync2_r[41:10];
  wire [11:0]       od_s  = sync2_r[53:42];
  // edges wait until the pipeline holds real pin values
  wire              arm   = settle_r[2];

  //////////////////////////////////////////////////////////////////////////
  // wishbone decode

  logic        ack_r;
  logic [31:0] rd_r;

  wire       req_w   = wb_cyc_in & wb_stb_in;
  wire       go_w    = req_w & ~ack_r;
  // writes land on the edge at which the master sees ack
  wire       wr_w    = req_w & wb_we_in & ack_r & wb_sel_in[0];
  wire [5:0] wa      = wb_adr_in[7:2];
  wire [2:0] grp     = wa[5:3];
  wire [2:0] sub     = wa[2:0];
  wire       hit_in  = wa == `PEP_W_IN;
  wire       hit_ctl = wa == `PEP_W_CTRL;
  wire       hit_flg = wa == `PEP_W_FLAG;
  wire       hit_dat = grp == `PEP_G_DATA;
  wire       hit_dir = grp == `PEP_G_DIR;
  wire       hit_od  = (grp == `PEP_G_OD) && (sub < `PEP_OD_CNT);
  wire       hit_pr  = (grp == `PEP_G_PAIR) && (sub < `PEP_PAIR_CNT);

  //////////////////////////////////////////////////////////////////////////
  // control, flags and edge inputs

  logic [`PEP_CTRL_W-1:0] ctrl_r;
  logic [1:0]             flag_r;
  logic [4:0]             irq_r;
  logic [`PEP_EDGES-1:0]  hit;
  pep_edge_e              mode [`PEP_EDGES];

  // order: dual, select a, select b, test a, test b, event a, event b
  wire [`PEP_EDGES-1:0] lvl = {evb_s, eva_s, pb_s, pa_s[0]};

  assign mode[0] = PEP_EDGE_BOTH;
  assign mode[1] = ctrl_r[`PEP_C_POL_A] ? PEP_EDGE_RISE
                                        : PEP_EDGE_FALL;
  assign mode[2] = ctrl_r[`PEP_C_POL_B] ? PEP_EDGE_RISE
                                        : PEP_EDGE_FALL;
  assign mode[3] = PEP_EDGE_RISE;
  assign mode[4] = PEP_EDGE_RISE;
  assign mode[5] = PEP_EDGE_RISE;
  assign mode[6] = PEP_EDGE_RISE;

  genvar e;
  generate
    for (e = 0; e < `PEP_EDGES; e++) begin : g_edge
      pep_edge_det u_edge (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_b_in),
        .arm_in   (arm),
        .level_in (lvl[e]),
        .mode_in  (mode[e]),
        .hit_out  (hit[e])
      );
    end
  endgenerate

  // test edges never reach irq_r; set beats a clear in the same cycle
  wire [1:0] flag_clr = (wr_w && hit_flg) ? wb_dat_in[1:0] : 2'h0;
  wire [1:0] flag_nxt = hit[4:3] | (flag_r & ~flag_clr);
  wire [4:0] irq_nxt  = {hit[6:5], hit[2:0]};

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_r <= `PEP_CTRL_RST;
      flag_r <= `PEP_FLAG_RST;
      irq_r  <= 5'h00;
    end else begin
      if (wr_w && hit_ctl) begin
        ctrl_r <= wb_dat_in[`PEP_CTRL_W-1:0];
      end
      flag_r <= flag_nxt;
      irq_r  <= irq_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ports 2..9

  pep_nib_t    dat_r [`PEP_IO_PORTS];
  pep_nib_t    dir_r [`PEP_IO_PORTS];
  logic [31:0] rb_flat;
  logic [31:0] dir_flat;
  logic [31:0] base_out;
  logic [31:0] base_oe;

  genvar k;
  generate
    for (k = 0; k < `PEP_IO_PORTS; k++) begin : g_port
      localparam bit BITWISE = (k == `PEP_BW_A) || (k == `PEP_BW_B);
      wire      own_w = wr_w && hit_dat && (sub == 3'(k));
      wire      dwr_w = wr_w && hit_dir && (sub == 3'(k));
      wire      pair_w;
      pep_nib_t pair_val;
      if (k >= 2) begin : g_pair
        assign pair_w   = wr_w && hit_pr && (sub == 3'((k - 2) / 2));
        assign pair_val = (k % 2 == 0) ? wb_dat_in[3:0]
                                       : wb_dat_in[7:4];
      end else begin : g_nopair
        assign pair_w   = 1'b0;
        assign pair_val = 4'h0;
      end
      wire pep_nib_t dir_val = BITWISE ? wb_dat_in[3:0]
                                       : {4{wb_dat_in[0]}};

      always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          dat_r[k] <= `PEP_DAT_RST;
          dir_r[k] <= `PEP_DIR_RST;
        end else begin
          if (own_w || pair_w) begin
            dat_r[k] <= own_w ? wb_dat_in[3:0] : pair_val;
          end
          if (dwr_w) begin
            dir_r[k] <= dir_val;
          end
        end
      end

      // output bits read back the latch, input bits the pin
      assign rb_flat[4*k +: 4]  = (dir_r[k] & dat_r[k]) |
                                  (~dir_r[k] & io_s[4*k +: 4]);
      assign dir_flat[4*k +: 4] = dir_r[k];
      assign base_out[4*k +: 4] = dat_r[k];
      assign base_oe[4*k +: 4]  = dir_r[k];

      if (!BITWISE) begin : g_chk
        property p_nibble_dir;
          @(posedge mclk_in) disable iff (!rst_b_in)
          (dir_r[k] == 4'h0) || (dir_r[k] == 4'hf);
        endproperty
        a_nibble_dir: assert property (p_nibble_dir)
          else $error("nibble port direction split across bits");
      end
    end
  endgenerate

  // alternate functions force a drive on their bit of port 2
  wire [2:0] alt_en  = {ctrl_r[`PEP_C_PCL], ctrl_r[`PEP_C_TO_B],
                        ctrl_r[`PEP_C_TO_A]};
  wire [2:0] alt_val = {prog_clock_src_in, timer_out_b_in, timer_out_a_in};
  wire [31:0] io_out_nxt = {base_out[31:3],
                            (alt_en & alt_val) |
                            (~alt_en & base_out[2:0])};
  wire [31:0] io_oe_nxt  = {base_oe[31:3],
                            alt_en | base_oe[2:0]};

  //////////////////////////////////////////////////////////////////////////
  // open-drain ports

  logic [11:0] od_flat;

  genvar j;
  generate
    for (j = 0; j < 3; j++) begin : g_od
      pep_nib_t od_r;
      wire      own_w = wr_w && hit_od && (sub == 3'(j));
      always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          od_r <= `PEP_OD_RST;
        end else if (own_w) begin
          od_r <= wb_dat_in[3:0];
        end
      end
      assign od_flat[4*j +: 4] = od_r;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // port a serial alternates

  wire       sck_drv = ctrl_r[`PEP_C_SCK_ALT] & sck_master_in;
  wire [3:0] p0_out_nxt = {1'b0, serial_tx_in, sck_drive_in, 1'b0};
  wire [3:0] p0_oe_nxt  = {1'b0, ctrl_r[`PEP_C_SO_ALT],
                           sck_drv, 1'b0};

  //////////////////////////////////////////////////////////////////////////
  // read mux and output flops

  wire [15:0] od_rb    = {4'h0, od_s};
  wire [4:0]  pr_base  = {sub[1:0] + 2'h1, 3'h0};
  wire [31:0] rdata    =
    hit_in  ? {22'h0, evb_s, eva_s, pb_s, pa_s} :
    hit_ctl ? {25'h0, ctrl_r} :
    hit_flg ? {30'h0, flag_r} :
    hit_dat ? {28'h0, rb_flat[{sub, 2'h0} +: 4]} :
    hit_dir ? {28'h0, dir_flat[{sub, 2'h0} +: 4]} :
    hit_od  ? {28'h0, od_rb[{sub[1:0], 2'h0} +: 4]} :
    hit_pr  ? {24'h0, rb_flat[pr_base +: 8]} :
              32'h0;

  logic [3:0]  p0_out_r;
  logic [3:0]  p0_oe_r;
  logic [31:0] io_out_r;
  logic [31:0] io_oe_r;
  logic [11:0] od_out_r;
  logic [11:0] od_oe_r;
  logic        sck_r;
  logic        rx_r;
  logic        eva_r;
  logic        evb_r;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_r    <= 1'b0;
      rd_r     <= 32'h0;
      p0_out_r <= 4'h0;
      p0_oe_r  <= 4'h0;
      io_out_r <= 32'h0;
      io_oe_r  <= 32'h0;
      od_out_r <= 12'h000;
      od_oe_r  <= 12'h000;
    end else begin
      ack_r    <= go_w;
      rd_r     <= go_w ? rdata : 32'h0;
      p0_out_r <= p0_out_nxt;
      p0_oe_r  <= p0_oe_nxt;
      io_out_r <= io_out_nxt;
      io_oe_r  <= io_oe_nxt;
      // a set latch bit releases the pin, a clear one pulls it low
      od_out_r <= 12'h000;
      od_oe_r  <= ~od_flat;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_r <= 1'b0;
      rx_r  <= 1'b0;
      eva_r <= 1'b0;
      evb_r <= 1'b0;
    end else begin
      sck_r <= pa_s[1];
      rx_r  <= pa_s[3];
      eva_r <= eva_s;
      evb_r <= evb_s;
    end
  end

  assign wb_dat_out             = rd_r;
  assign wb_ack_out             = ack_r;
  assign input_port_a_drv_out   = p0_out_r;
  assign input_port_a_oe_out    = p0_oe_r;
  assign port_pins_out          = io_out_r;
  assign port_pins_oe_out       = io_oe_r;
  assign open_drain_pins_out    = od_out_r;
  assign open_drain_pins_oe_out = od_oe_r;
  assign sck_sync_out           = sck_r;
  assign serial_rx_out          = rx_r;
  assign event_a_out            = eva_r;
  assign event_b_out            = evb_r;
  assign irq_req_out            = irq_r;
  assign test_flag_out          = flag_r;

  //////////////////////////////////////////////////////////////////////////
  // checks

  property p_dual_edge;
    @(posedge mclk_in) disable iff (!rst_b_in)
    arm && $changed(lvl[0]) |=> irq_r[0];
  endproperty
  a_dual_edge: assert property (p_dual_edge)
    else $error("dual-edge input edge gave no request");

  property p_once;
    @(posedge mclk_in) disable iff (!rst_b_in)
    !$changed(lvl[0]) |=> !irq_r[0];
  endproperty
  a_once: assert property (p_once)
    else $error("request without a fresh edge");

  property p_sel_rise;
    @(posedge mclk_in) disable iff (!rst_b_in)
    arm && $rose(lvl[1]) && ctrl_r[`PEP_C_POL_A] |=> irq_r[1];
  endproperty
  a_sel_rise: assert property (p_sel_rise)
    else $error("selected rising edge missed");

  property p_sel_fall_only;
    @(posedge mclk_in) disable iff (!rst_b_in)
    $rose(lvl[2]) && !ctrl_r[`PEP_C_POL_B] |=> !irq_r[2];
  endproperty
  a_sel_fall_only: assert property (p_sel_fall_only)
    else $error("rising edge fired while falling edge selected");

  property p_test_flag;
    @(posedge mclk_in) disable iff (!rst_b_in)
    arm && $rose(lvl[3]) |=> flag_r[0] && (irq_r == $past(irq_nxt));
  endproperty
  a_test_flag: assert property (p_test_flag)
    else $error("test edge did not set its flag");

  property p_timer_alt;
    @(posedge mclk_in) disable iff (!rst_b_in)
    ctrl_r[`PEP_C_TO_A] |=> io_oe_r[0] && io_out_r[0] == $past(timer_out_a_in);
  endproperty
  a_timer_alt: assert property (p_timer_alt)
    else $error("timer output not on port 2 bit 0");

  property p_sck_drive;
    @(posedge mclk_in) disable iff (!rst_b_in)
    !sck_drv |=> !p0_oe_r[1];
  endproperty
  a_sck_drive: assert property (p_sck_drive)
    else $error("serial clock driven while not master");

  property p_open_drain;
    @(posedge mclk_in) disable iff (!rst_b_in)
    1'b1 |=> od_out_r == 12'h000 && od_oe_r == ~$past(od_flat);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin driven high or wrong enable");

  property p_pair_write;
    @(posedge mclk_in) disable iff (!rst_b_in)
    wr_w && hit_pr && sub == 3'h0 |=> dat_r[2] == $past(wb_dat_in[3:0])
                                     && dat_r[3] == $past(wb_dat_in[7:4]);
  endproperty
  a_pair_write: assert property (p_pair_write)
    else $error("pair write did not reach both ports");

  property p_ack_once;
    @(posedge mclk_in) disable iff (!rst_b_in)
    ack_r |=> !ack_r;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held beyond one cycle");

endmodule

// ===== bench/pep_pins_model.sv
/*
  Outside circuits on the port pads: resolves each pad from the block's
  enables and the level the outside world applies.
  Assumes the bench sets the outside levels; open-drain pads are pulled up.
*/
module pep_pins_model (
  // pads driven by the block
  input  wire logic [3:0]  a_drv_in,
  input  wire logic [3:0]  a_oe_in,
  input  wire logic [31:0] io_drv_in,
  input  wire logic [31:0] io_oe_in,
  input  wire logic [11:0] od_oe_in,
  // levels from the outside circuits
  input  wire logic [3:0]  ext_a_in,
  input  wire logic [31:0] ext_io_in,
  input  wire logic [11:0] ext_od_in,
  // resolved pad levels
  output logic      [3:0]  pad_a_out,
  output logic      [31:0] pad_io_out,
  output logic      [11:0] pad_od_out
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////
  // a pad the block enables shows the block's level, else the outside one
  assign pad_a_out = (a_oe_in & a_drv_in) | (~a_oe_in & ext_a_in);
  assign pad_io_out = (io_oe_in & io_drv_in) | (~io_oe_in & ext_io_in);
  // pull-low wins; a released pad shows its pull-up or outside level
  assign pad_od_out = ~od_oe_in & ext_od_in;
endmodule

// ===== bench/pep_port_top_bench.sv
/*
  Self-checking bench of the port pin block: Wishbone accesses and pad
  stimulus with expected values.
  Assumes the pad model above and the design's one-cycle ack.
*/
module pep_port_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pep_pkg::*;
  logic            mclk_in = 1'b0;
  logic            rst_b_in = 1'b0;
  logic            cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]      adr = 8'h00;
  logic [3:0]      sel = 4'h0;
  logic [31:0]     wdat = 32'h0, rdat, r, ext_io = 32'h0;
  logic [31:0]     io_in, io_out, io_oe;
  pep_nib_t        ext_a = 4'h0, ext_b = 4'h0, pa, a_drv, a_oe;
  logic [1:0]      ext_ev = 2'h0, flg;
  logic [11:0]     ext_od = 12'hfff, od_in, od_out, od_oe;
  logic [5:0]      src = 6'h00;
  logic [4:0]      irq;
  logic            ev_a, ev_b, sck_s, rx;
  int              mismatches = 0, samples_checked = 0, cycles = 0;
  int              irq_cnt [5];

  ////////////////////////////////////////////////////////////////////////
  pep_port_top i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .input_port_a_in(pa), .input_port_b_in(ext_b),
    .event_in_a_in(ext_ev[0]), .event_in_b_in(ext_ev[1]),
    .input_port_a_drv_out(a_drv), .input_port_a_oe_out(a_oe),
    .port_pins_in(io_in), .port_pins_out(io_out), .port_pins_oe_out(io_oe),
    .open_drain_pins_in(od_in), .open_drain_pins_out(od_out),
    .open_drain_pins_oe_out(od_oe), .timer_out_a_in(src[0]),
    .timer_out_b_in(src[1]), .prog_clock_src_in(src[2]),
    .sck_master_in(src[3]), .sck_drive_in(src[4]), .serial_tx_in(src[5]),
    .sck_sync_out(sck_s), .serial_rx_out(rx), .event_a_out(ev_a),
    .event_b_out(ev_b), .irq_req_out(irq), .test_flag_out(flg));

  pep_pins_model i_pads (.a_drv_in(a_drv), .a_oe_in(a_oe),
    .io_drv_in(io_out), .io_oe_in(io_oe), .od_oe_in(od_oe),
    .ext_a_in(ext_a), .ext_io_in(ext_io), .ext_od_in(ext_od),
    .pad_a_out(pa), .pad_io_out(io_in), .pad_od_out(od_in));

  ////////////////////////////////////////////////////////////////////////
  always #50 mclk_in = ~mclk_in;

  // the ceiling is over thirty times the length of the whole sequence
  always @(posedge mclk_in) begin
    cycles++;
    for (int i = 0; i < 5; i++) irq_cnt[i] += int'(irq[i] === 1'b1);
    if (cycles == 6000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    // no limit of its own; ack or the bench timeout ends this wait
    do begin
      @(posedge mclk_in);
    end while (ack !== 1'b1);
    r = rdat;
    chk("ack", {31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask

  // sample pulse count after the synchroniser and detector have run
  task automatic edge_t(input string nm, input int i, input int exp);
    int c0;
    @(negedge mclk_in);
    c0 = irq_cnt[i];
    wait_n(6);
    chk(nm, irq_cnt[i] - c0, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    wait_n(3);
    chk("io_oe", io_oe, 32'h0);
    chk("a_oe", {28'h0, a_oe}, 32'h0);
    chk("od_oe", {20'h0, od_oe}, 32'h0);
    wb(1'b0, 8'h04, 32'h0); chk("ctrl", r, 32'h0);
    $display("test reset done");

    @(posedge mclk_in);
    ext_a <= 4'ha;
    ext_b <= 4'h5;
    ext_ev <= 2'h1;
    wait_n(4);
    wb(1'b0, 8'h00, 32'h0); chk("in", r, 32'h15a);
    chk("flag", {30'h0, flg}, 32'h1);
    chk("irq_ev", irq_cnt[3], 1);
    chk("ev_lvl", {31'h0, ev_a}, 32'h1);
    chk("irq_vec", irq_cnt[0] + irq_cnt[1] + irq_cnt[2], 0);
    chk("sck_in", {31'h0, sck_s}, 32'h1);
    chk("rx", {31'h0, rx}, 32'h1);
    wb(1'b1, 8'h08, 32'h1);
    wb(1'b0, 8'h08, 32'h0); chk("flag_clr", r, 32'h0);
    $display("test inputs done");

    @(posedge mclk_in) ext_a[0] <= 1'b1;
    edge_t("dual_rise", 0, 1);
    @(posedge mclk_in) ext_a[0] <= 1'b0;
    edge_t("dual_fall", 0, 1);
    wb(1'b1, 8'h04, 32'h4);
    @(posedge mclk_in) ext_b[0] <= 1'b0;
    edge_t("sel_a_fall", 1, 0);
    @(posedge mclk_in) ext_b[0] <= 1'b1;
    edge_t("sel_a_rise", 1, 1);
    wb(1'b1, 8'h04, 32'h0);
    @(posedge mclk_in) ext_b[1] <= 1'b1;
    edge_t("sel_b_rise", 2, 0);
    @(posedge mclk_in) ext_b[1] <= 1'b0;
    edge_t("sel_b_fall", 2, 1);
    @(posedge mclk_in) ext_b[3] <= 1'b1;
    edge_t("test_b", 2, 0);
    chk("flag_b", {30'h0, flg}, 32'h2);
    @(posedge mclk_in) ext_ev[1] <= 1'b1;
    edge_t("ev_b", 4, 1);
    chk("ev_b_lvl", {31'h0, ev_b}, 32'h1);
    $display("test edges done");

    wb(1'b1, 8'h44, 32'h5);
    wb(1'b1, 8'h48, 32'h1);
    wb(1'b1, 8'h4c, 32'he);
    wait_n(2);
    chk("dir3", io_oe[7:4], 32'h5);
    chk("dir45", io_oe[15:8], 32'h0f);
    wb(1'b1, 8'h24, 32'hf);
    wb(1'b0, 8'h24, 32'h0); chk("p3", r, 32'h5);
    wb(1'b1, 8'h4c, 32'h1);
    wb(1'b1, 8'h80, 32'h3c);
    wait_n(2);
    chk("pair_pins", io_out[15:8], 32'h3c);
    wb(1'b0, 8'h80, 32'h0); chk("pair_rd", r, 32'h3c);
    wb(1'b0, 8'h2c, 32'h0); chk("p5", r, 32'h3);
    $display("test ports done");

    wb(1'b1, 8'h60, 32'h6);
    wait_n(3);
    chk("od_oe", {20'h0, od_oe}, 32'h9);
    chk("od_out", {20'h0, od_out}, 32'h0);
    wb(1'b0, 8'h60, 32'h0); chk("od_rd", r, 32'h6);
    wb(1'b0, 8'h6c, 32'h0); chk("unmapped", r, 32'h0);
    $display("test open drain done");

    @(posedge mclk_in) src <= 6'h3f;
    wb(1'b1, 8'h04, 32'h73);
    wait_n(2);
    chk("alt_out", io_out[2:0], 32'h7);
    chk("alt_oe", io_oe[2:0], 32'h7);
    chk("ser_oe", a_oe[2:1], 32'h3);
    chk("ser_drv", a_drv[2:1], 32'h3);
    @(posedge mclk_in) src <= 6'h00;
    wait_n(2);
    chk("alt_low", io_out[2:0], 32'h0);
    chk("ser_low", a_drv[2:1], 32'h0);
    $display("test alternates done");

    // reset in mid-run must drop every drive, even with alternates on
    @(posedge mclk_in) rst_b_in <= 1'b0;
    wait_n(2);
    chk("rst_io_oe", io_oe, 32'h0);
    chk("rst_a_oe", {28'h0, a_oe}, 32'h0);
    chk("rst_od_oe", {20'h0, od_oe}, 32'h0);
    @(posedge mclk_in) rst_b_in <= 1'b1;
    wait_n(6);
    chk("rst_flag", {30'h0, flg}, 32'h0);
    wb(1'b0, 8'h04, 32'h0); chk("rst_ctrl", r, 32'h0);
    $display("test second reset done");
    conclude();
  end
endmodule
